// >>> logic/osd_pkg.sv
// constants shared by the octal driver serial control logic
package osd_pkg;

    // channel count and frame length
    localparam int CHAN_N = 8;

    // width of the bundle carried through the pin synchroniser: chip select plus sense bits
    localparam int SYNC_W = CHAN_N + 1;

    // bit position of chip select inside the synchronised bundle
    localparam int SYNC_CE_POS = CHAN_N;

    // reset values of shift register, parallel latch and channel drive
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DRIVE_RST = 8'h00;

    // reset value of the synchroniser stages (chip select idles high)
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h100;

    // system clock rate
    localparam int CLK_KHZ = 40000;

    // fault protection release delay after chip select rises, in microseconds
    localparam int FAULT_CLR_MIN_US = 75;
    localparam int FAULT_CLR_MAX_US = 250;

    // least delay in clock cycles, rounded up
    localparam int FAULT_CLR_CYC = (FAULT_CLR_MIN_US * CLK_KHZ + 999) / 1000;

    // delay counter width and terminal count
    localparam int FCNT_W = 12;
    localparam logic [FCNT_W-1:0] FCNT_LAST = FCNT_W'(FAULT_CLR_CYC - 1);
    localparam logic [FCNT_W-1:0] FCNT_ONE  = 12'h001;
    localparam logic [FCNT_W-1:0] FCNT_RST  = 12'h000;

endpackage

// >>> logic/osd_sync_if.sv
// carrier between the pin synchroniser and the serial control core
`timescale 1ns/1ps
`default_nettype none
interface osd_sync_if;
    import osd_pkg::*;
    logic [SYNC_W-1:0] raw;     // asynchronous pin levels
    logic [SYNC_W-1:0] synced;  // levels after two flip-flops

    // synchroniser side
    modport sync (input raw, output synced);
    // core side
    modport user (output raw, input synced);
endinterface
`default_nettype wire

// >>> logic/osd_sync.sv
// two flip-flop synchroniser for the chip select and sense pins
`timescale 1ns/1ps
`default_nettype none
module osd_sync
    import osd_pkg::*;
(
    // clock and reset
    input wire logic    clk,
    input wire logic    rst,
    // pin bundle in, synchronised bundle out
    osd_sync_if.sync    bus
);

    logic [SYNC_W-1:0] meta_q;   // first stage, read only by the second stage
    logic [SYNC_W-1:0] meta_d;
    logic [SYNC_W-1:0] sync_q;   // second stage, safe to use
    logic [SYNC_W-1:0] sync_d;

    // next values: plain shift through both stages
    always_comb begin
        meta_d = bus.raw;
        sync_d = meta_q;
    end

    // register stages
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign bus.synced = sync_q;

endmodule
`default_nettype wire

// >>> logic/osd_serial_ctrl.sv
// serial control and diagnostic logic of an octal low-side driver
// Notes on behaviour
// R1: eight-bit frames through an eight-stage shift register
// R2: channel seven first, channel zero last
// R3: serial out driven only while chip select low
// R4: serial out shows last stage, allows chaining
// R5: serial out advances on rising serial clock
// R6: serial in sampled on falling serial clock
// R7: command one switches channel off, zero on
// R8: chip select rise copies shift into latch
// R9: chip select fall loads sense bits
// R10: sense bit one means output pin high
// R11: controller compares sense with previous command
// R12: returned frame shows overload and open load
// R13: active-low reset clears shift, latch, outputs asynchronously
// R14: fault protection released 75 to 250 us later
// R15: controller gives eight falling edges per device
`timescale 1ns/1ps
`default_nettype none
module osd_serial_ctrl
    import osd_pkg::*;
(
    // system clock and synchronous reset
    input  wire logic           clk,
    input  wire logic           rst,
    // serial link from the controller
    input  wire logic           sclk,
    input  wire logic           ceN,
    input  wire logic           si,
    output logic                so,
    output logic                soOe,
    // asynchronous clear pin
    input  wire logic           resetN,
    // output stages
    input  wire logic [7:0]     senseHi,
    output logic [7:0]          chanOn,
    output logic                faultRst
);

    // ------------------------------------------------------------------
    // clock domain of the system clock: pin synchronisers
    // ------------------------------------------------------------------

    osd_sync_if syncBus ();          // carrier to and from the synchroniser

    assign syncBus.raw = {ceN, senseHi};

    osd_sync u_sync (
        .clk (clk),
        .rst (rst),
        .bus (syncBus.sync)
    );

    logic       ceS;                 // chip select after synchroniser
    logic [7:0] senseS;              // sense bits after synchroniser

    assign ceS    = syncBus.synced[SYNC_CE_POS];
    assign senseS = syncBus.synced[CHAN_N-1:0];

    // ------------------------------------------------------------------
    // link clock domain: shift register and serial output
    // ------------------------------------------------------------------

    logic       linkClr;             // asynchronous clear of link state
    logic       frameClr;            // ends a frame: chip select high or clear
    logic [7:0] shiftQ;              // eight-stage shift register
    logic [7:0] shiftD;
    logic       startedQ;            // a falling edge has been seen in this frame
    logic       soQ;                 // serial output stage
    logic       soD;
    logic [7:0] snapQ;               // sense snapshot, from the system domain

    // the clear pin acts without any clock; chip select high ends a frame
    assign linkClr  = ~resetN;                 // [R13]
    assign frameClr = ceN | ~resetN;

    // next shift value: the first edge of a frame starts from the snapshot
    // so the sense bits leave ahead of the command bits
    always_comb begin
        shiftD = shiftQ;
        if (!ceN) begin
            if (startedQ) begin
                shiftD = {shiftQ[6:0], si};     // [R1] [R6]
            end else begin
                shiftD = {snapQ[6:0], si};      // [R9]
            end
        end
    end

    // shift register samples on falling serial clock
    always_ff @(negedge sclk or posedge linkClr) begin
        if (linkClr) begin
            shiftQ <= SHIFT_RST;                // [R13]
        end else begin
            shiftQ <= shiftD;
        end
    end

    // frame flag: set by the first falling edge, cleared at once by chip select
    always_ff @(negedge sclk or posedge frameClr) begin
        if (frameClr) begin
            startedQ <= 1'b0;
        end else begin
            startedQ <= 1'b1;
        end
    end

    // next serial output: channel seven sense bit before the first shift,
    // then the last stage so a second device can be chained behind
    always_comb begin
        if (startedQ) begin
            soD = shiftQ[7];                    // [R4]
        end else begin
            soD = snapQ[7];                     // [R2]
        end
    end

    // serial output advances on rising serial clock
    always_ff @(posedge sclk or posedge linkClr) begin
        if (linkClr) begin
            soQ <= 1'b0;
        end else begin
            soQ <= soD;                         // [R5]
        end
    end

    assign so = soQ;

    // ------------------------------------------------------------------
    // system domain: edge detect, snapshot, latch, drive, fault timer
    // ------------------------------------------------------------------

    logic              cePrevQ;      // chip select one cycle back
    logic              ceFall;       // frame opens
    logic              ceRise;       // frame closes
    logic [7:0]        snapD;
    logic [7:0]        latchQ;       // parallel command latch
    logic [7:0]        latchD;
    logic              enabledQ;     // a command has been latched since reset
    logic              enabledD;
    logic [7:0]        chanOnQ;      // channel drive, one means switched on
    logic [7:0]        chanOnD;
    logic              soOeQ;        // serial output driver enable
    logic              soOeD;
    logic              busyQ;        // fault release timer running
    logic              busyD;
    logic [FCNT_W-1:0] cntQ;         // fault release timer
    logic [FCNT_W-1:0] cntD;
    logic              faultRstQ;    // fault protection release pulse
    logic              faultRstD;

    assign ceFall = cePrevQ & ~ceS;
    assign ceRise = ~cePrevQ & ceS;

    // next values of the system domain
    always_comb begin
        // sense bits are the pin levels themselves, so a stuck-high or
        // stuck-low pin shows up against the command the controller sent
        snapD = ceFall ? senseS : snapQ;                // [R9] [R10] [R12]
        // shift register is quiet once chip select is high, and the edge
        // reaches here two cycles late, so the word is stable when taken;
        // a frame with other than eight falling edges latches garbage
        latchD = ceRise ? shiftQ : latchQ;              // [R8] [R15]
        enabledD = enabledQ | ceRise;
        // a one in the latch switches the channel off
        chanOnD = enabledQ ? ~latchQ : DRIVE_RST;       // [R7]
        // driver on only while chip select is low
        soOeD = ~ceS;                                   // [R3]
        // fault release timer, restarted by every frame end
        busyD     = busyQ;
        cntD      = cntQ;
        faultRstD = 1'b0;
        if (ceRise) begin
            busyD = 1'b1;
            cntD  = FCNT_RST;
        end else if (busyQ) begin
            if (cntQ == FCNT_LAST) begin
                busyD     = 1'b0;
                faultRstD = 1'b1;                       // [R14]
            end else begin
                cntD = cntQ + FCNT_ONE;
            end
        end
    end

    // registers of the system domain; the clear pin acts without the clock
    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            cePrevQ   <= 1'b1;
            snapQ     <= SHIFT_RST;
            latchQ    <= LATCH_RST;                     // [R13]
            enabledQ  <= 1'b0;
            chanOnQ   <= DRIVE_RST;                     // [R13]
            busyQ     <= 1'b0;
            cntQ      <= FCNT_RST;
            faultRstQ <= 1'b0;
        end else if (rst) begin
            cePrevQ   <= 1'b1;
            snapQ     <= SHIFT_RST;
            latchQ    <= LATCH_RST;
            enabledQ  <= 1'b0;
            chanOnQ   <= DRIVE_RST;
            busyQ     <= 1'b0;
            cntQ      <= FCNT_RST;
            faultRstQ <= 1'b0;
        end else begin
            cePrevQ   <= ceS;
            snapQ     <= snapD;
            latchQ    <= latchD;
            enabledQ  <= enabledD;
            chanOnQ   <= chanOnD;
            busyQ     <= busyD;
            cntQ      <= cntD;
            faultRstQ <= faultRstD;
        end
    end

    // driver enable: chip select high clears it at once, without the clock,
    // so the pin is released as the frame ends; it only rises once the
    // synchronised chip select has caught up with the pin
    always_ff @(posedge clk or posedge frameClr) begin
        if (frameClr) begin
            soOeQ <= 1'b0;                              // [R3]
        end else if (rst) begin
            soOeQ <= 1'b0;
        end else begin
            soOeQ <= soOeD;
        end
    end

    assign chanOn   = chanOnQ;
    assign soOe     = soOeQ;
    assign faultRst = faultRstQ;

    // ------------------------------------------------------------------
    // checks, system domain
    // ------------------------------------------------------------------

    chk_latch_transfer: assert property ( // [R8]
        @(posedge clk) disable iff (rst || !resetN)
        ceRise |=> latchQ == $past(shiftQ))
        else $error("latch did not take the shift register at frame end");

    chk_sense_snapshot: assert property ( // [R9]
        @(posedge clk) disable iff (rst || !resetN)
        ceFall |=> snapQ == $past(senseS) ##1 $stable(snapQ))
        else $error("sense snapshot not taken at frame start");

    chk_so_enable: assert property ( // [R3]
        @(posedge clk) disable iff (rst || !resetN)
        ceS[*2] |-> !soOe)
        else $error("serial output driven while chip select high");

    chk_chan_polarity: assert property ( // [R7]
        @(posedge clk) disable iff (rst || !resetN)
        enabledQ ##1 enabledQ |-> chanOn == ~$past(latchQ))
        else $error("channel drive does not match latched command");

    chk_reset_clear: assert property ( // [R13]
        @(posedge clk) disable iff (rst)
        !resetN |-> latchQ == LATCH_RST && chanOn == DRIVE_RST)
        else $error("clear pin did not clear latch and outputs");

    chk_fault_delay: assert property ( // [R14]
        @(posedge clk) disable iff (rst || !resetN)
        faultRst |-> $past(cntQ) == FCNT_LAST && !busyQ)
        else $error("fault release not at the programmed delay");

    chk_timer_start: assert property ( // [R14]
        @(posedge clk) disable iff (rst || !resetN)
        ceRise |=> busyQ && cntQ == FCNT_RST && !faultRst)
        else $error("fault release timer not restarted at frame end");

    // ------------------------------------------------------------------
    // checks, link domain
    // ------------------------------------------------------------------

    chk_shift_in: assert property ( // [R6]
        @(negedge sclk) disable iff (linkClr)
        !ceN |=> shiftQ[0] == $past(si))
        else $error("serial input not sampled on falling clock");

    chk_last_stage: assert property ( // [R4]
        @(posedge sclk) disable iff (linkClr)
        startedQ |=> soQ == $past(shiftQ[7]))
        else $error("serial output is not the last stage");

    chk_first_bit: assert property ( // [R2]
        @(posedge sclk) disable iff (linkClr)
        !startedQ |=> soQ == $past(snapQ[7]))
        else $error("first bit out is not channel seven sense");

endmodule
`default_nettype wire

// >>> bench/osd_ctrl_model.sv
// controller side model: bus master of the serial link
`timescale 1ns/1ps
`default_nettype none
module osd_ctrl_model
    import osd_pkg::*;
(
    // link pins driven by the controller
    output logic        sclk,
    output logic        ceN,
    output logic        si,
    // data line back from the driver
    input  wire logic   so,
    input  wire logic   soOe
);
    localparam realtime HALF = 62.5;  // half of the 125 ns link period
    logic lastSo;                      // last level seen on the data line
    int   oeLow;                       // samples taken while the line was released
    int   oeHigh;                      // line still driven just after chip select rose
    wire  soBus;                       // resolved data line

    // a released line shows the inverse of its last level, never a held value
    assign soBus = soOe ? so : ~lastSo;

    // link idles with clock low and chip select high
    initial begin
        sclk = 1'b0;
        ceN = 1'b1;
        si = 1'b0;
        lastSo = 1'b0;
        oeLow = 0;
        oeHigh = 0;
    end

    // one frame of n bits, most significant first on both lines
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = '0;
        ceN = 1'b0;
        #253.7;  // snapshot settles; odd offset keeps link edges off clk edges
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            sclk = 1'b1;
            #HALF;
            if (soOe !== 1'b1) begin
                oeLow++;
            end
            rx[i] = soBus;
            lastSo = soBus;
            sclk = 1'b0;
            #HALF;
        end
        ceN = 1'b1;
        #5;
        if (soOe !== 1'b0) begin
            oeHigh++;
        end
        si = ~si;  // data line of no meaning outside frames
        #295;
    endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench of the octal driver serial control
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import osd_pkg::*;
    logic        clk;       // system clock
    logic        rst;       // synchronous reset
    logic        resetN;    // asynchronous clear pin
    logic [7:0]  senseHi;   // output pin levels
    wire         sclk;      // link clock from the model
    wire         ceN;       // chip select from the model
    wire         si;        // serial in from the model
    wire         so;        // serial out
    wire         soOe;      // serial out enable
    wire         faultRst;  // fault release pulse
    wire [7:0]   chanOn;    // channel drive
    int          fails;     // mismatches
    int          numChecks; // comparisons
    int          gap;       // cycles since chip select rose
    int          seenGap;   // gap when the release pulse came
    logic        ceD;       // chip select one cycle ago
    logic [31:0] rnd;       // random state
    logic [7:0]  prevCmd;   // command of the frame before
    logic [15:0] lastRx;    // frame returned by the last transfer
    bit          timedOut;  // watchdog ran out

    osd_serial_ctrl i_osd_serial_ctrl (.clk(clk), .rst(rst), .sclk(sclk), .ceN(ceN), .si(si),
        .so(so), .soOe(soOe), .resetN(resetN), .senseHi(senseHi), .chanOn(chanOn),
        .faultRst(faultRst));
    osd_ctrl_model i_osd_ctrl_model (.sclk(sclk), .ceN(ceN), .si(si), .so(so), .soOe(soOe));

    // system clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // measure the delay from chip select rise to the release pulse
    always @(negedge clk) begin
        if (rst) begin
            ceD     <= 1'b1;
            gap     <= 0;
            seenGap <= -1;
        end else begin
            ceD <= ceN;
            gap <= (ceN === 1'b1 && ceD === 1'b0) ? 0 : gap + 1;
            if (faultRst === 1'b1) begin
                seenGap <= gap;
            end
        end
    end

    // linear feedback shift register step
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // closing verdict, reached from the main sequence or the watchdog
    task automatic final_report;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0 && !timedOut) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one frame with given sense levels; expected frame and drive from a shift model
    task automatic frame(input logic [7:0] sense, input logic [15:0] tx, input int n);
        logic [7:0]  s;
        logic [15:0] rx;
        logic [15:0] ex;
        @(negedge clk);
        senseHi = sense;
        s = sense;
        ex = '0;
        for (int i = n - 1; i >= 0; i--) begin
            ex[i] = s[7];
            s = {s[6:0], tx[i]};
        end
        i_osd_ctrl_model.xfer(tx, n, rx);
        lastRx = rx;
        `CHK(rx, ex)
        repeat (4) @(negedge clk);
        `CHK(chanOn, ~s)
        `CHK(soOe, 1'b0)
    endtask

    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        timedOut = 1'b1;
        final_report;
    end

    // main sequence
    initial begin
        rst = 1'b1;
        resetN = 1'b1;
        senseHi = 8'h00;
        fails = 0;
        numChecks = 0;
        rnd = 32'h421CDFC1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        `CHK(chanOn, 8'h00)
        // corner values of sense and command
        frame(8'h00, 16'h00FF, 8);
        frame(8'hFF, 16'h0000, 8);
        frame(8'h80, 16'h0001, 8);
        $display("corner frames done");
        // random traffic: sense follows the previous command except where a
        // fault is injected, and the controller must find that pattern again
        prevCmd = 8'h01;
        for (int k = 0; k < 20; k++) begin
            rnd = lfsr(rnd);
            frame(prevCmd ^ rnd[23:16], {8'h00, rnd[15:8]}, 8);
            `CHK(lastRx[7:0] ^ prevCmd, rnd[23:16])
            prevCmd = rnd[15:8];
        end
        $display("random frames done");
        // chained pair: own sense first, then the bits fed in
        rnd = lfsr(rnd);
        frame(rnd[23:16], rnd[15:0], 16);
        // short frame latches whatever stands in the register
        frame(8'hC3, 16'h000A, 4);
        $display("chain and short frames done");
        // fault protection release delay
        frame(8'h5A, 16'h00A5, 8);
        for (int w = 0; w < 3100 && seenGap < 0; w++) begin
            @(negedge clk);
        end
        `CHK(seenGap >= FAULT_CLR_CYC && seenGap <= FAULT_CLR_CYC + 6, 1'b1)
        $display("fault release done");
        // asynchronous clear in mid-run, away from clock edges
        frame(8'h00, 16'h0000, 8);
        #3;
        resetN = 1'b0;
        #2;
        `CHK(chanOn, 8'h00)
        repeat (3) @(negedge clk);
        `CHK(soOe, 1'b0)
        resetN = 1'b1;
        repeat (5) @(negedge clk);
        `CHK(chanOn, 8'h00)
        frame(8'h3C, 16'h0066, 8);
        `CHK(i_osd_ctrl_model.oeLow, 0)
        `CHK(i_osd_ctrl_model.oeHigh, 0)
        $display("clear pin done");
        final_report;
    end
endmodule
`default_nettype wire
